// file: pdmc_ctrl.sv
// power-down mode controller: mode sequencer, wait counter and avalon-mm register slave
// assumes sleep_exec, ext_irq, any_irq and bus_cycle_end are one-cycle pulses on mclk
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pdmc_ctrl
  import pdmc_pkg::*;
#(
  parameter pdmc_wait_t WAIT_STATES [8] = WAIT_TABLE
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire pdmc_avs_req_t avs_req,
  output logic [31:0]        readdata,
  output logic               waitrequest,
  input  wire logic          sleep_exec,
  input  wire logic          ext_irq,
  input  wire logic          any_irq,
  input  wire logic          bus_cycle_end,
  output pdmc_gate_t         gate
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration check

  for (genvar g = 0; g < 8; g++) begin : g_wait_chk
    if (WAIT_STATES[g] == '0) begin : g_bad
      $error("wait table entry must be nonzero");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    pdmc_mode_t  mode;
    pdmc_mode_t  resume;
    logic        standby_select;
    logic [2:0]  sts;
    logic        bus_output_hold;
    logic        prescaler_subclock_select;
    logic        low_speed_on_flag;
    logic        direct_transfer_on;
    logic [2:0]  sck;
    logic [7:0]  mstp;
    pdmc_wait_t  wcnt;
    logic        ack;
    logic [31:0] rdata;
    logic        exc;
  } pdmc_regs_t;

  pdmc_regs_t s_q;
  pdmc_regs_t s_d;

  function automatic pdmc_mode_t run_mode(input logic [2:0] sel);
    run_mode = (sel != 3'h0) ? md_medium : md_high;
  endfunction : run_mode

  function automatic logic is_standby_like(input pdmc_mode_t m);
    is_standby_like = (m == md_standby) || (m == md_watch) || (m == md_osc_wait);
  endfunction : is_standby_like

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic req;
  logic take;
  logic wr_lane0;
  logic keyed_ok;

  assign req      = avs_req.read | avs_req.write;
  assign take     = req & s_q.ack;
  assign wr_lane0 = take & avs_req.write & avs_req.byteenable[0];
  assign keyed_ok = avs_req.byteenable[1:0] == 2'b11 && avs_req.writedata[15:8] == WRITE_KEY;

  assign waitrequest = req & ~s_q.ack;
  assign readdata    = s_q.rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [7:0] wd;
    s_d      = s_q;
    s_d.exc  = 1'b0;
    wd       = avs_req.writedata[7:0];

    // one wait cycle per request, answer on the next edge
    s_d.ack = req & ~s_q.ack;
    if (req && !s_q.ack && avs_req.read) begin
      unique case (avs_req.address[4:2])
        OFS_STANDBY_CONTROL[4:2]: s_d.rdata = {24'h0, s_q.standby_select, s_q.sts, s_q.bus_output_hold, 3'h0};
        OFS_KEYED_TIMER[4:2]:     s_d.rdata = {27'h0, s_q.prescaler_subclock_select, 4'h0};
        OFS_MODULE_STOP_A[4:2]:   s_d.rdata = {24'h0, s_q.mstp};
        OFS_LOW_POWER[4:2]:       s_d.rdata = {30'h0, s_q.low_speed_on_flag, s_q.direct_transfer_on};
        OFS_SYSTEM_CLOCK[4:2]:    s_d.rdata = {29'h0, s_q.sck};
        OFS_STATUS[4:2]:          s_d.rdata = {28'h0, s_q.mode == md_osc_wait, s_q.mode};
        default:                  s_d.rdata = 32'h0;
      endcase
    end

    // register writes
    if (take && avs_req.write) begin
      unique case (avs_req.address[4:2])
        OFS_STANDBY_CONTROL[4:2]: begin
          if (wr_lane0) begin
            s_d.standby_select = wd[POS_STANDBY_SELECT];
            s_d.sts  = wd[POS_WAIT_SELECT +: 3];
            s_d.bus_output_hold  = wd[POS_BUS_HOLD];
          end
        end
        OFS_KEYED_TIMER[4:2]: begin
          if (keyed_ok) begin
            s_d.prescaler_subclock_select = wd[POS_PRESCALER_SEL];
          end
        end
        OFS_MODULE_STOP_A[4:2]: begin
          if (wr_lane0) begin
            s_d.mstp = wd;
          end
        end
        OFS_LOW_POWER[4:2]: begin
          if (wr_lane0) begin
            s_d.low_speed_on_flag = wd[POS_LOW_SPEED_ON];
            s_d.direct_transfer_on = wd[POS_DIRECT_XFER];
          end
        end
        OFS_SYSTEM_CLOCK[4:2]: begin
          if (wr_lane0) begin
            s_d.sck = wd[2:0];
          end
        end
        default: begin
        end
      endcase
    end

    // mode sequencer; control bits sampled as they stood before this edge
    unique case (s_q.mode)
      md_high, md_medium: begin
        if (sleep_exec) begin
          if (!s_q.standby_select && !s_q.low_speed_on_flag) begin
            s_d.mode = md_sleep;
          end else if (s_q.standby_select && !s_q.prescaler_subclock_select && !s_q.low_speed_on_flag) begin
            s_d.mode = md_standby;
          end else if (s_q.standby_select && s_q.prescaler_subclock_select && !s_q.direct_transfer_on) begin
            s_d.mode = md_watch;
          end else if (s_q.standby_select && s_q.prescaler_subclock_select && s_q.low_speed_on_flag && s_q.direct_transfer_on) begin
            s_d.mode = md_sub_active;
          end
          // other combinations are forbidden and leave the mode alone
        end else if (bus_cycle_end) begin
          s_d.mode = run_mode(s_q.sck);
        end
      end
      md_sleep: begin
        if (any_irq) begin
          s_d.mode = run_mode(s_q.sck);
          s_d.exc  = 1'b1;
        end
      end
      md_sub_active: begin
        if (sleep_exec) begin
          if (!s_q.standby_select && s_q.prescaler_subclock_select && s_q.low_speed_on_flag) begin
            s_d.mode = md_sub_sleep;
          end else if (s_q.standby_select && s_q.prescaler_subclock_select && !s_q.direct_transfer_on) begin
            s_d.mode = md_watch;
          end else if (s_q.standby_select && s_q.prescaler_subclock_select && !s_q.low_speed_on_flag && s_q.direct_transfer_on) begin
            s_d.mode   = md_osc_wait;
            s_d.resume = md_high;
            s_d.wcnt   = WAIT_STATES[s_q.sts];
          end
        end
      end
      md_sub_sleep: begin
        if (any_irq) begin
          s_d.mode = md_sub_active;
          s_d.exc  = 1'b1;
        end
      end
      md_watch: begin
        if (ext_irq) begin
          s_d.mode   = md_osc_wait;
          s_d.resume = s_q.low_speed_on_flag ? md_sub_active : md_high;
          s_d.wcnt   = WAIT_STATES[s_q.sts];
        end
      end
      md_standby: begin
        if (ext_irq) begin
          s_d.mode   = md_osc_wait;
          s_d.resume = run_mode(s_q.sck);
          s_d.wcnt   = WAIT_STATES[s_q.sts];
        end
      end
      md_osc_wait: begin
        if (s_q.wcnt == WAIT_W'(1)) begin
          s_d.mode = s_q.resume;
          s_d.exc  = 1'b1;
          s_d.wcnt = '0;
        end else begin
          s_d.wcnt = s_q.wcnt - WAIT_W'(1);
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q        <= '0;
      s_q.mode   <= md_high;
      s_q.resume <= md_high;
      s_q.sts    <= RST_WAIT_SELECT;
      s_q.bus_output_hold    <= RST_BUS_HOLD;
      s_q.mstp   <= RST_MODULE_STOP_A;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    gate.mode            = s_q.mode;
    gate.cpu_halt        = s_q.mode inside {md_sleep, md_sub_sleep, md_watch, md_standby,
                                            md_osc_wait};
    gate.master_slow     = s_q.mode == md_medium;
    gate.sub_clock_all   = s_q.mode == md_sub_active;
    gate.dma_stop        = s_q.mstp[POS_DMA_STOP] | is_standby_like(s_q.mode);
    gate.timer_stop      = s_q.mstp[POS_TIMER_STOP] | is_standby_like(s_q.mode);
    gate.converter_reset = s_q.mstp[POS_CONVERTER_STOP] | is_standby_like(s_q.mode)
                           | s_q.mode == md_sub_active | s_q.mode == md_sub_sleep;
    gate.bus_float       = is_standby_like(s_q.mode) & ~s_q.bus_output_hold;
    gate.exc_start       = s_q.exc;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  a_sleep_entry: assert property (@(posedge mclk) disable iff (rst)
    (s_q.mode inside {md_high, md_medium}) && sleep_exec && !s_q.standby_select && !s_q.low_speed_on_flag
    |=> gate.mode == md_sleep && gate.cpu_halt)
    else $error("sleep not entered");

  a_subsleep_entry: assert property (@(posedge mclk) disable iff (rst)
    s_q.mode == md_sub_active && sleep_exec && !s_q.standby_select && s_q.prescaler_subclock_select && s_q.low_speed_on_flag
    |=> gate.mode == md_sub_sleep)
    else $error("sub-sleep not entered");

  a_standby_entry: assert property (@(posedge mclk) disable iff (rst)
    (s_q.mode inside {md_high, md_medium}) && sleep_exec && s_q.standby_select && !s_q.prescaler_subclock_select && !s_q.low_speed_on_flag
    |=> gate.mode == md_standby)
    else $error("software standby not entered");

  a_pss_low_limit: assert property (@(posedge mclk) disable iff (rst)
    (s_q.mode inside {md_high, md_medium}) && sleep_exec && !s_q.prescaler_subclock_select
    |=> !(gate.mode inside {md_watch, md_sub_active}))
    else $error("watch or sub-active reached with prescaler-select low");

  a_watch_entry: assert property (@(posedge mclk) disable iff (rst)
    (s_q.mode inside {md_high, md_medium}) && sleep_exec && s_q.standby_select && s_q.prescaler_subclock_select && !s_q.direct_transfer_on
    |=> gate.mode == md_watch)
    else $error("watch not entered");

  a_direct_high: assert property (@(posedge mclk) disable iff (rst)
    s_q.mode == md_sub_active && sleep_exec && s_q.standby_select && s_q.prescaler_subclock_select && !s_q.low_speed_on_flag && s_q.direct_transfer_on
    |=> gate.mode == md_osc_wait ##1 gate.mode == md_osc_wait)
    else $error("direct transition did not wait");

  a_standby_select_kept: assert property (@(posedge mclk) disable iff (rst)
    s_q.mode == md_standby && ext_irq && !(take && avs_req.write)
    |=> $stable(s_q.standby_select))
    else $error("standby-select changed by wakeup");

  a_wait_load: assert property (@(posedge mclk) disable iff (rst)
    $rose(s_q.mode == md_osc_wait) |-> s_q.wcnt == WAIT_STATES[$past(s_q.sts)])
    else $error("wait count not loaded from table");

  a_wake_exc: assert property (@(posedge mclk) disable iff (rst)
    s_q.mode == md_osc_wait && s_q.wcnt == WAIT_W'(1)
    |=> gate.exc_start && gate.mode == $past(s_q.resume) ##1 !gate.exc_start)
    else $error("wakeup did not start exception handling");

  a_bus_float: assert property (@(posedge mclk) disable iff (rst)
    gate.bus_float == ((gate.mode inside {md_standby, md_watch, md_osc_wait}) && !s_q.bus_output_hold))
    else $error("bus float level wrong for mode");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
    take && avs_req.read && avs_req.address[4:2] == OFS_STANDBY_CONTROL[4:2]
    |-> readdata[2:0] == 3'h0)
    else $error("reserved standby bits not zero");

  a_key_reject: assert property (@(posedge mclk) disable iff (rst)
    take && avs_req.write && avs_req.address[4:2] == OFS_KEYED_TIMER[4:2] && !keyed_ok
    |=> $stable(s_q.prescaler_subclock_select))
    else $error("unkeyed write changed prescaler-select");

  a_stop_write: assert property (@(posedge mclk) disable iff (rst)
    wr_lane0 && avs_req.address[4:2] == OFS_MODULE_STOP_A[4:2]
    && avs_req.writedata[POS_TIMER_STOP] && s_q.mode == md_high && !sleep_exec
    |=> gate.timer_stop)
    else $error("timer stop bit did not stop the timer");

  a_medium_switch: assert property (@(posedge mclk) disable iff (rst)
    s_q.mode == md_high && s_q.sck != 3'h0 && bus_cycle_end && !sleep_exec
    |=> gate.mode == md_medium && gate.master_slow)
    else $error("medium speed not entered at bus cycle end");

  a_answer_one: assert property (@(posedge mclk) disable iff (rst)
    req && !s_q.ack |-> waitrequest ##1 !waitrequest)
    else $error("bus answer late");

  a_reset_state: assert property (@(posedge mclk) disable iff (rst)
    $fell(rst) |-> gate.mode == md_high && !gate.dma_stop && gate.timer_stop && s_q.bus_output_hold)
    else $error("reset state wrong");

  a_medium_scope: assert property (@(posedge mclk) disable iff (rst)
    gate.mode == md_medium |-> gate.master_slow && !gate.sub_clock_all && !gate.cpu_halt)
    else $error("medium speed gates wrong");

  a_sub_scope: assert property (@(posedge mclk) disable iff (rst)
    gate.mode == md_sub_active |-> gate.sub_clock_all && !gate.master_slow && !gate.cpu_halt)
    else $error("sub-clock active gates wrong");

  a_sub_to_watch: assert property (@(posedge mclk) disable iff (rst)
    s_q.mode == md_sub_active && sleep_exec && s_q.standby_select && s_q.prescaler_subclock_select && !s_q.direct_transfer_on
    |=> gate.mode == md_watch)
    else $error("watch not entered from sub-clock active");

  a_subactive_entry: assert property (@(posedge mclk) disable iff (rst)
    (s_q.mode inside {md_high, md_medium}) && sleep_exec && s_q.standby_select && s_q.prescaler_subclock_select && s_q.low_speed_on_flag
    && s_q.direct_transfer_on |=> gate.mode == md_sub_active)
    else $error("sub-clock active not entered");

  a_sleep_wake: assert property (@(posedge mclk) disable iff (rst)
    s_q.mode == md_sleep && any_irq
    |=> gate.exc_start && (gate.mode inside {md_high, md_medium}))
    else $error("sleep wakeup wrong");

  a_subsleep_wake: assert property (@(posedge mclk) disable iff (rst)
    s_q.mode == md_sub_sleep && any_irq |=> gate.exc_start && gate.mode == md_sub_active)
    else $error("sub-sleep wakeup wrong");

  a_standby_wake: assert property (@(posedge mclk) disable iff (rst)
    s_q.mode == md_standby && ext_irq |=> gate.mode == md_osc_wait && gate.cpu_halt)
    else $error("standby wakeup did not start the wait");

  a_watch_resume: assert property (@(posedge mclk) disable iff (rst)
    s_q.mode == md_watch && ext_irq
    |=> gate.mode == md_osc_wait && s_q.resume == ($past(s_q.low_speed_on_flag) ? md_sub_active : md_high))
    else $error("watch wakeup target wrong");

  a_stop_only_set: assert property (@(posedge mclk) disable iff (rst)
    (gate.mode inside {md_high, md_medium, md_sleep})
    |-> gate.dma_stop == s_q.mstp[POS_DMA_STOP]
    && gate.timer_stop == s_q.mstp[POS_TIMER_STOP])
    else $error("module stopped without its stop bit");

  a_converter_reset: assert property (@(posedge mclk) disable iff (rst)
    (gate.mode inside {md_standby, md_watch, md_osc_wait, md_sub_active, md_sub_sleep})
    |-> gate.converter_reset)
    else $error("converter not held in reset");

  a_key_accept: assert property (@(posedge mclk) disable iff (rst)
    take && avs_req.write && avs_req.address[4:2] == OFS_KEYED_TIMER[4:2] && keyed_ok
    |=> s_q.prescaler_subclock_select == $past(avs_req.writedata[POS_PRESCALER_SEL]))
    else $error("keyed write not taken");

  a_wait_count: assert property (@(posedge mclk) disable iff (rst)
    s_q.mode == md_osc_wait && s_q.wcnt != WAIT_W'(1)
    |=> gate.mode == md_osc_wait && s_q.wcnt == $past(s_q.wcnt) - WAIT_W'(1))
    else $error("wait count did not step");

endmodule : pdmc_ctrl

// file: pdmc_pkg.sv
// package for the power-down mode controller: register map, fields, modes, bus carriers
// assumes one 10 mhz clock and a cpu that pulses a sleep request per executed sleep
// Functional notes
// - reset gives full speed, all stopped but dma
// - medium slows masters; sub-clock slows all three
// - sleep at full/medium speed, standby-select 0
// - sleep in sub-clock active, standby-select 0: sub-sleep
// - standby-select 1 at speed: standby, sub-active, watch
// - standby-select 1 in sub-active: watch or full
// - prescaler-select 0: only sleep or software standby
// - prescaler-select 1 at speed: sleep, watch, sub-active
// - prescaler-select 1 in sub-active: sub-sleep, watch, full
// - standby exit keeps standby-select; software clears it
// - wait-select field picks stabilization wait states
// - bus output bit floats or holds bus outputs
// - standby control low three bits read zero
// - keyed register takes only key a5 word writes
// - keyed register reads need no key
// - stop bit one stops module, zero runs it
// - dma stop bit 7 reset 0, timer bit 5 reset 1
// - only set modules halt; retained keep registers (standby, watch and the wait state also halt dma and timer)
// - halted-reset modules are initialized
// - nonzero clock select gives medium after bus cycle
package pdmc_pkg;

  // register byte offsets
  localparam logic [4:0] OFS_STANDBY_CONTROL = 5'h00;
  localparam logic [4:0] OFS_KEYED_TIMER     = 5'h04;
  localparam logic [4:0] OFS_MODULE_STOP_A   = 5'h08;
  localparam logic [4:0] OFS_LOW_POWER       = 5'h0c;
  localparam logic [4:0] OFS_SYSTEM_CLOCK    = 5'h10;
  localparam logic [4:0] OFS_STATUS          = 5'h14;

  // field positions
  localparam int POS_STANDBY_SELECT = 7;
  localparam int POS_WAIT_SELECT    = 4;
  localparam int POS_BUS_HOLD       = 3;
  localparam int POS_PRESCALER_SEL  = 4;
  localparam int POS_LOW_SPEED_ON   = 1;
  localparam int POS_DIRECT_XFER    = 0;
  localparam int POS_DMA_STOP       = 7;
  localparam int POS_TIMER_STOP     = 5;
  localparam int POS_CONVERTER_STOP = 1;
  localparam int POS_WAIT_BUSY      = 3;

  // reset values and key
  localparam logic [7:0] RST_MODULE_STOP_A = 8'h3f;
  localparam logic [2:0] RST_WAIT_SELECT   = 3'h0;
  localparam logic       RST_BUS_HOLD      = 1'b1;
  localparam logic [7:0] WRITE_KEY         = 8'ha5;

  // stabilization wait in states, indexed by the wait-select code
  localparam int WAIT_W = 19;
  typedef logic [WAIT_W-1:0] pdmc_wait_t;
  localparam pdmc_wait_t WAIT_TABLE [8] = '{19'h02000, 19'h04000, 19'h08000, 19'h10000,
                                           19'h20000, 19'h40000, 19'h00800, 19'h00010};

  typedef enum logic [2:0] {
    md_high, md_medium, md_sleep, md_sub_active, md_sub_sleep, md_watch, md_standby, md_osc_wait
  } pdmc_mode_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } pdmc_avs_req_t;

  typedef struct packed {
    pdmc_mode_t mode;
    logic       cpu_halt;
    logic       master_slow;
    logic       sub_clock_all;
    logic       dma_stop;
    logic       timer_stop;
    logic       converter_reset;
    logic       bus_float;
    logic       exc_start;
  } pdmc_gate_t;

endpackage : pdmc_pkg

// file: tb_top.sv
// testbench for pdmc_ctrl: register map, sleep transitions, stabilization waits, reset
// assumes pdmc_pkg and pdmc_ctrl are compiled first; drives all ports itself
`timescale 1ns/1ps
module tb_top import pdmc_pkg::*;;
  typedef struct packed {
    logic [7:0] sc;
    logic       prescaler_subclock_select;
    logic [7:0] lp;
    logic [1:0] irq;
    pdmc_mode_t m1;
    logic       w;
    pdmc_mode_t m2;
    logic       fl;
  } pdmc_row_t;

  localparam pdmc_wait_t WS [8] = '{19'h8, 19'h9, 19'ha, 19'hb, 19'hc, 19'hd, 19'h4, 19'h2};
  // sleep rows: control values, wake source (1 any, 2 ext), modes, float level
  localparam pdmc_row_t ROWS [11] = '{
    '{8'h08, 1'b0, 8'h00, 2'h1, md_sleep, 1'b0, md_high, 1'b0},
    '{8'h80, 1'b0, 8'h00, 2'h2, md_standby, 1'b1, md_high, 1'b1},
    '{8'he8, 1'b1, 8'h00, 2'h2, md_watch, 1'b1, md_high, 1'b0},
    '{8'hf8, 1'b1, 8'h02, 2'h2, md_watch, 1'b1, md_sub_active, 1'b0},
    '{8'h18, 1'b1, 8'h02, 2'h1, md_sub_sleep, 1'b0, md_sub_active, 1'b0},
    '{8'ha8, 1'b1, 8'h01, 2'h0, md_osc_wait, 1'b1, md_high, 1'b0},
    '{8'h08, 1'b1, 8'h02, 2'h0, md_high, 1'b0, md_high, 1'b0},
    '{8'h90, 1'b0, 8'h00, 2'h2, md_standby, 1'b1, md_high, 1'b1},
    '{8'hb8, 1'b0, 8'h00, 2'h2, md_standby, 1'b1, md_high, 1'b0},
    '{8'hc0, 1'b0, 8'h00, 2'h2, md_standby, 1'b1, md_high, 1'b1},
    '{8'hd8, 1'b0, 8'h00, 2'h2, md_standby, 1'b1, md_high, 1'b0}};

  logic          mclk;
  logic          rst;
  logic          sleep_exec;
  logic          ext_irq;
  logic          any_irq;
  logic          bus_cycle_end;
  pdmc_avs_req_t avs_req;
  logic [31:0]   readdata;
  logic [31:0]   q;
  logic          waitrequest;
  pdmc_gate_t    gate;
  pdmc_row_t     r;
  int            fails;
  int            checks_done;
  int            n;

  pdmc_ctrl #(.WAIT_STATES(WS)) u_pdmc_ctrl (
    .mclk(mclk), .rst(rst), .avs_req(avs_req), .readdata(readdata),
    .waitrequest(waitrequest), .sleep_exec(sleep_exec), .ext_irq(ext_irq),
    .any_irq(any_irq), .bus_cycle_end(bus_cycle_end), .gate(gate));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk

  task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int k;
    @(posedge mclk);
    avs_req <= '{read: rd, write: !rd, address: a, writedata: d, byteenable: be};
    #1;
    k = 0;
    while (waitrequest !== 1'b0 && k < 50) begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k == 50) begin
      $display("mismatch waitrequest expected 0 seen 1");
      fails++;
      close_out();
    end
    @(posedge mclk);
    q = readdata;
    avs_req <= '0;
    #1;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(1'b0, a, d, be);
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string nm);
    bus(1'b1, a, 32'h0, 4'hf);
    chk(nm, e, q);
  endtask : rdc

  // 0 sleep, 1 any interrupt, 2 external interrupt, 3 bus cycle end
  task automatic pulse(input int s);
    @(posedge mclk);
    sleep_exec    <= (s == 0);
    any_irq       <= (s == 1);
    ext_irq       <= (s == 2);
    bus_cycle_end <= (s == 3);
    @(posedge mclk);
    sleep_exec    <= 1'b0;
    any_irq       <= 1'b0;
    ext_irq       <= 1'b0;
    bus_cycle_end <= 1'b0;
    #1;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    sleep_exec = 1'b0;
    ext_irq = 1'b0;
    any_irq = 1'b0;
    bus_cycle_end = 1'b0;
    avs_req = '0;
    fails = 0;
    checks_done = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("mode", 32'(md_high), 32'(gate.mode));
    chk("dma stop", 32'h0, 32'(gate.dma_stop));
    chk("timer stop", 32'h1, 32'(gate.timer_stop));
    rdc(OFS_STANDBY_CONTROL, 32'h08, "standby_control");
    rdc(OFS_KEYED_TIMER, 32'h0, "keyed_timer_power_control");
    rdc(OFS_MODULE_STOP_A, 32'h3f, "module_stop_control_a");
    $display("test reset done");
    wr(OFS_STANDBY_CONTROL, 32'h07, 4'h1);
    rdc(OFS_STANDBY_CONTROL, 32'h0, "standby low bits");
    wr(OFS_KEYED_TIMER, 32'h0010, 4'h3);
    rdc(OFS_KEYED_TIMER, 32'h0, "keyed without key");
    wr(OFS_KEYED_TIMER, 32'ha510, 4'h1);
    rdc(OFS_KEYED_TIMER, 32'h0, "keyed byte write");
    wr(OFS_KEYED_TIMER, 32'ha510, 4'h3);
    rdc(OFS_KEYED_TIMER, 32'h10, "keyed word write");
    wr(5'h18, 32'hff, 4'hf);
    rdc(5'h18, 32'h0, "unmapped");
    wr(OFS_MODULE_STOP_A, 32'h80, 4'h1);
    rdc(OFS_MODULE_STOP_A, 32'h80, "stop write");
    chk("dma stop", 32'h1, 32'(gate.dma_stop));
    chk("timer stop", 32'h0, 32'(gate.timer_stop));
    chk("converter reset", 32'h0, 32'(gate.converter_reset));
    wr(OFS_MODULE_STOP_A, 32'h00, 4'h1);
    chk("dma stop", 32'h0, 32'(gate.dma_stop));
    $display("test registers done");
    for (int i = 0; i < 11; i++) begin
      r = ROWS[i];
      wr(OFS_STANDBY_CONTROL, {24'h0, r.sc}, 4'h1);
      wr(OFS_KEYED_TIMER, {16'h0, WRITE_KEY, 3'h0, r.prescaler_subclock_select, 4'h0}, 4'h3);
      wr(OFS_LOW_POWER, {24'h0, r.lp}, 4'h1);
      rdc(OFS_LOW_POWER, {24'h0, r.lp}, "low_power_control");
      pulse(0);
      chk("mode after sleep", 32'(r.m1), 32'(gate.mode));
      chk("cpu halt", 32'(!(r.m1 inside {md_high, md_sub_active})), 32'(gate.cpu_halt));
      if (r.m1 inside {md_standby, md_watch}) begin
        chk("bus float", 32'(r.fl), 32'(gate.bus_float));
        chk("dma stop", 32'h1, 32'(gate.dma_stop));
        chk("converter reset", 32'h1, 32'(gate.converter_reset));
      end
      if (r.irq != 2'h0) begin
        pulse(int'(r.irq));
      end
      if (r.w) begin
        n = 0;
        while (gate.mode === md_osc_wait && n < 1000) begin
          @(posedge mclk);
          #1;
          n++;
        end
        if (n == 1000) begin
          $display("mismatch wait states expected %0d seen %0d", WS[r.sc[6:4]], n);
          fails++;
          close_out();
        end
        chk("wait states", 32'(WS[r.sc[6:4]]), 32'(n));
      end
      chk("mode after wake", 32'(r.m2), 32'(gate.mode));
      if (r.irq != 2'h0 || !r.w) begin
        chk("exception start", 32'(r.irq != 2'h0), 32'(gate.exc_start));
      end
      if (r.m2 == md_sub_active) begin
        chk("sub clock", 32'h1, 32'(gate.sub_clock_all));
      end
      rdc(OFS_STANDBY_CONTROL, {24'h0, r.sc & 8'hf8}, "standby kept");
    end
    $display("test transitions done");
    wr(OFS_SYSTEM_CLOCK, 32'h3, 4'h1);
    chk("mode before cycle end", 32'(md_high), 32'(gate.mode));
    pulse(3);
    chk("mode medium", 32'(md_medium), 32'(gate.mode));
    chk("master slow", 32'h1, 32'(gate.master_slow));
    rdc(OFS_SYSTEM_CLOCK, 32'h3, "system_clock_control");
    rdc(OFS_STATUS, 32'(md_medium), "status medium");
    chk("sub clock", 32'h0, 32'(gate.sub_clock_all));
    wr(OFS_STANDBY_CONTROL, 32'h08, 4'h1);
    pulse(0);
    chk("medium sleep", 32'(md_sleep), 32'(gate.mode));
    pulse(1);
    chk("medium resume", 32'(md_medium), 32'(gate.mode));
    wr(OFS_SYSTEM_CLOCK, 32'h0, 4'h1);
    pulse(3);
    chk("mode high", 32'(md_high), 32'(gate.mode));
    $display("test medium done");
    wr(OFS_MODULE_STOP_A, 32'hff, 4'h1);
    wr(OFS_SYSTEM_CLOCK, 32'h1, 4'h1);
    pulse(3);
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("mode after reset", 32'(md_high), 32'(gate.mode));
    rdc(OFS_MODULE_STOP_A, 32'h3f, "stop after reset");
    rdc(OFS_STANDBY_CONTROL, 32'h08, "standby after reset");
    $display("test second reset done");
    close_out();
  end
endmodule : tb_top
